// file: vfcr_params.svh
// Register indices, field positions, reset values and fixed bits of the front-end bank
`ifndef VFCR_PARAMS_SVH
`define VFCR_PARAMS_SVH

// Register indices; the Avalon byte address is four times the index
`define VFCR_IDX_PORT_CLK_GAIN 8'h41
`define VFCR_IDX_SYNC_CTRL 8'h45
`define VFCR_IDX_AGC_ENABLE 8'h46
`define VFCR_IDX_GAIN_CH1 8'h47
`define VFCR_IDX_GAIN_CH2 8'h48
`define VFCR_IDX_GAIN_CH3 8'h49
`define VFCR_IDX_GAIN_CH4 8'h4a
`define VFCR_IDX_ADC_REF 8'h4b
`define VFCR_IDX_POWER_DOWN 8'h4c
`define VFCR_IDX_LOSS_MODE 8'h4d
`define VFCR_IDX_FREERUN 8'h4f
`define VFCR_IDX_PEAK_CH12 8'h50
`define VFCR_IDX_PEAK_CH34 8'h51
`define VFCR_IDX_CLAMP_TEST 8'h52
`define VFCR_IDX_STATUS 8'h55
`define VFCR_IDX_ANALOG_TEST 8'h56
`define VFCR_IDX_CORING_SW 8'h57

// Reset values as read back, fixed bits included
`define VFCR_RST_PORT_CLK_GAIN 8'h77
`define VFCR_RST_SYNC_CTRL 8'hd1
`define VFCR_RST_AGC_ENABLE 8'h00
`define VFCR_RST_GAIN_LOW 8'hf0
`define VFCR_RST_ADC_REF 8'h02
`define VFCR_RST_POWER_DOWN 8'h00
`define VFCR_RST_LOSS_MODE 8'h0f
`define VFCR_RST_FREERUN 8'h05
`define VFCR_RST_PEAK 8'h00
`define VFCR_RST_CLAMP_TEST 8'h00
`define VFCR_RST_ANALOG_TEST 8'h00
`define VFCR_RST_CORING_SW 8'h30

// Writable bit masks and fixed bits that always read back
`define VFCR_MASK_PORT_CLK_GAIN 8'hf7
`define VFCR_MASK_SYNC_CTRL 8'h3c
`define VFCR_FIX_SYNC_CTRL 8'hc1
`define VFCR_MASK_ADC_REF 8'h63
`define VFCR_MASK_POWER_DOWN 8'h3f
`define VFCR_MASK_LOSS_MODE 8'h0c
`define VFCR_FIX_LOSS_MODE 8'h03
`define VFCR_MASK_CLAMP_TEST 8'hdf

// Field positions
`define VFCR_POS_PCLK_OE 7
`define VFCR_POS_GAIN_C 4
`define VFCR_POS_GAIN_Y 0
`define VFCR_POS_VSYNC_ALIGN_SELECT 5
`define VFCR_POS_FIELD_FLAG_POLARITY 4
`define VFCR_POS_HSYNC_POLARITY 3
`define VFCR_POS_VSYNC_POLARITY 2
`define VFCR_POS_AGC_OFF 4
`define VFCR_POS_GAIN_MSB 0
`define VFCR_POS_CURRENT_REF_BOOST 6
`define VFCR_POS_VREF 5
`define VFCR_POS_VAA 1
`define VFCR_POS_VLP 0
`define VFCR_POS_AUDIO_DAC_POWER_DOWN 5
`define VFCR_POS_AUDIO_ADC_POWER_DOWN 4
`define VFCR_POS_VIDEO_ADC_POWER_DOWN 0
`define VFCR_POS_LOSS 2
`define VFCR_POS_FMR 6
`define VFCR_POS_YNR 4
`define VFCR_POS_CLAMP_MODE_SELECT 2
`define VFCR_POS_PSP 0
`define VFCR_POS_AAA 4
`define VFCR_POS_CORING 4
`define VFCR_POS_INSEL 0

// DAC gain base in 1/32 units: code 0 is 29/32 = 90.625 percent
`define VFCR_DAC_GAIN_BASE 6'h1d

`endif

// file: vfcr_pkg.sv
// Types shared by the front-end configuration bank
package vfcr_pkg;

  typedef logic [7:0] vfcr_byte_t;
  typedef logic [8:0] vfcr_gain_t;

  typedef enum logic {
    VFCR_BUS_ACCEPT = 1'b0,
    VFCR_BUS_FINISH = 1'b1
  } vfcr_bus_state_t;

endpackage

// file: vfcr_sync_shaper.sv
// One channel of sync and field flag shaping
`timescale 1ns/1ns
module vfcr_sync_shaper
  import vfcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic vsync_align_select_i,
  input wire logic field_flag_polarity_i,
  input wire logic hsync_polarity_i,
  input wire logic vsync_polarity_i,
  // Raw timing, active high sync
  input wire logic hsync_raw_i,
  input wire logic vsync_raw_i,
  input wire logic odd_field_i,
  // Shaped outputs
  output logic hsync_o,
  output logic vsync_o,
  output logic field_o
);

  logic hs_prev_reg;
  logic vs_lat_reg;
  logic odd_lat_reg;
  wire hs_rise = hsync_raw_i & ~hs_prev_reg;
  // Aligned to hsync: vsync and field change only at a hsync leading edge
  wire vs_sel = vsync_align_select_i ? vs_lat_reg : vsync_raw_i; // [R2]
  wire odd_sel = vsync_align_select_i ? odd_lat_reg : odd_field_i; // [R2]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_prev_reg <= 1'b0;
      vs_lat_reg <= 1'b0;
      odd_lat_reg <= 1'b0;
      hsync_o <= 1'b1;
      vsync_o <= 1'b1;
      field_o <= 1'b0;
    end else begin
      hs_prev_reg <= hsync_raw_i;
      if (hs_rise) begin
        vs_lat_reg <= vsync_raw_i;
        odd_lat_reg <= odd_field_i;
      end
      hsync_o <= hsync_polarity_i ? hsync_raw_i : ~hsync_raw_i; // [R4]
      vsync_o <= vsync_polarity_i ? vs_sel : ~vs_sel; // [R5]
      field_o <= field_flag_polarity_i ? ~odd_sel : odd_sel; // [R3]
    end
  end

endmodule

// file: vfcr_gain_select.sv
// One channel of AGC gain selection between loop and manual value
`timescale 1ns/1ns
module vfcr_gain_select
  import vfcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic auto_gain_loop_off_i,
  input wire vfcr_gain_t manual_gain_value_i,
  input wire vfcr_gain_t loop_gain_i,
  // Result
  output vfcr_gain_t gain_o
);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_o <= 9'h000;
    end else begin
      gain_o <= auto_gain_loop_off_i ? manual_gain_value_i : loop_gain_i; // [R6]
    end
  end

endmodule

// file: vfcr_top.sv
// Video front-end configuration and status register bank on Avalon-MM
//
// Overview of operation
// [R1] DAC gain 90.625 to 112.5 percent, steps
// [R2] Vsync and field aligned to vsync or hsync
// [R3] Field flag high odd or even
// [R4] Hsync output polarity select
// [R5] Vsync output polarity select
// [R6] Per-channel AGC loop off uses manual gain
// [R7] Nine-bit manual gain, split, reset 0f0
// [R8] Current reference boost bit
// [R9] Voltage reference shut-down bit
// [R10] Video anti-alias enable and low power
// [R11] Audio and video converter power-down bits
// [R12] No-video flag speed, reset slowest
// [R13] Free-run rate auto, 60 or 50
// [R14] Luma noise reduction level
// [R15] Clamping mode, reset automatic
// [R16] Slice level, reset medium
// [R17] Audio input anti-alias enable
// [R18] Read-only field status per channel
// [R19] Read-only vertical active status per channel
// [R20] Per-channel analog input A or B
// [R21] Sharpness coring nibble, reset 3
// [R22] Port clock pins driven only when enabled
// [R23] Software rewrites fixed bits as shown
`timescale 1ns/1ns
`include "vfcr_params.svh"
module vfcr_top
  import vfcr_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Avalon-MM slave
  input wire logic [9:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Decoder timing, per channel, from core logic
  input wire logic [3:0] HSYNC_RAW_I,
  input wire logic [3:0] VSYNC_RAW_I,
  input wire logic [3:0] ODD_FIELD_I,
  input wire logic [3:0] VACTIVE_I,
  input wire logic [35:0] LOOP_GAIN_I,
  // Port clock sources
  input wire logic [1:0] PORT_CLK_SRC_I,
  // Sync outputs
  output logic [3:0] HSYNC_O,
  output logic [3:0] VSYNC_O,
  output logic [3:0] FIELD_O,
  // Port clock pins
  output logic [1:0] PORT_CLK_O,
  output logic [1:0] PORT_CLK_OE_O,
  // DAC gain in 1/32 units
  output logic [5:0] DAC_GAIN_Y_O,
  output logic [5:0] DAC_GAIN_C_O,
  // Channel gain
  output logic [3:0] AGC_LOOP_OFF_O,
  output logic [35:0] CH_GAIN_O,
  // Analog front-end control
  output logic CUR_REF_BOOST_O,
  output logic VOLT_REF_OFF_O,
  output logic VIDEO_AA_EN_O,
  output logic VIDEO_LOW_POWER_O,
  output logic AUDIO_DAC_PD_O,
  output logic AUDIO_ADC_PD_O,
  output logic [3:0] VIDEO_ADC_PD_O,
  output logic [1:0] LOSS_FLAG_SPEED_O,
  output logic [1:0] FREERUN_SELECT_O,
  output logic [1:0] LUMA_NOISE_REDUCE_O,
  output logic [1:0] CLAMP_MODE_O,
  output logic [1:0] SLICE_LEVEL_O,
  output logic AUDIO_AA_EN_O,
  output logic [15:0] PEAKING_TEST_O,
  output logic [7:0] CLAMP_TEST_O,
  output logic [7:0] ANALOG_TEST_O,
  output logic [3:0] INPUT_SOURCE_SEL_O,
  output logic [3:0] SHARP_CORING_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  vfcr_bus_state_t bus_state_reg;
  vfcr_byte_t rd_byte;
  wire [7:0] reg_index = AVS_ADDRESS_I[9:2];
  wire bus_req = AVS_READ_I | AVS_WRITE_I;
  // Every access takes one wait state, so read data can come from a flop
  wire bus_done = bus_req & (bus_state_reg == VFCR_BUS_FINISH);
  wire wr_go = bus_done & AVS_WRITE_I & AVS_BYTEENABLE_I[0];

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      bus_state_reg <= VFCR_BUS_ACCEPT;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      unique case (bus_state_reg)
        VFCR_BUS_ACCEPT: begin
          if (bus_req) begin
            bus_state_reg <= VFCR_BUS_FINISH;
            AVS_WAITREQUEST_O <= 1'b0;
            AVS_READDATA_O <= {24'h00_0000, rd_byte};
          end
        end
        VFCR_BUS_FINISH: begin
          bus_state_reg <= VFCR_BUS_ACCEPT;
          AVS_WAITREQUEST_O <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire hit_pclk = reg_index == `VFCR_IDX_PORT_CLK_GAIN;
  wire hit_sync = reg_index == `VFCR_IDX_SYNC_CTRL;
  wire hit_agc = reg_index == `VFCR_IDX_AGC_ENABLE;
  wire hit_g1 = reg_index == `VFCR_IDX_GAIN_CH1;
  wire hit_g2 = reg_index == `VFCR_IDX_GAIN_CH2;
  wire hit_g3 = reg_index == `VFCR_IDX_GAIN_CH3;
  wire hit_g4 = reg_index == `VFCR_IDX_GAIN_CH4;
  wire hit_ref = reg_index == `VFCR_IDX_ADC_REF;
  wire hit_pd = reg_index == `VFCR_IDX_POWER_DOWN;
  wire hit_loss = reg_index == `VFCR_IDX_LOSS_MODE;
  wire hit_fr = reg_index == `VFCR_IDX_FREERUN;
  wire hit_pk12 = reg_index == `VFCR_IDX_PEAK_CH12;
  wire hit_pk34 = reg_index == `VFCR_IDX_PEAK_CH34;
  wire hit_ct = reg_index == `VFCR_IDX_CLAMP_TEST;
  wire hit_st = reg_index == `VFCR_IDX_STATUS;
  wire hit_at = reg_index == `VFCR_IDX_ANALOG_TEST;
  wire hit_cs = reg_index == `VFCR_IDX_CORING_SW;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  vfcr_byte_t pclk_reg;
  vfcr_byte_t sync_reg;
  vfcr_byte_t agc_reg;
  vfcr_byte_t g1_reg;
  vfcr_byte_t g2_reg;
  vfcr_byte_t g3_reg;
  vfcr_byte_t g4_reg;
  vfcr_byte_t ref_reg;
  vfcr_byte_t pd_reg;
  vfcr_byte_t loss_reg;
  vfcr_byte_t fr_reg;
  vfcr_byte_t pk12_reg;
  vfcr_byte_t pk34_reg;
  vfcr_byte_t ct_reg;
  vfcr_byte_t at_reg;
  vfcr_byte_t cs_reg;
  vfcr_byte_t wd;
  assign wd = AVS_WRITEDATA_I[7:0];

  // Fixed bits are not stored; they read back at their fixed value
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pclk_reg <= `VFCR_RST_PORT_CLK_GAIN & `VFCR_MASK_PORT_CLK_GAIN; // [R1] [R22]
      sync_reg <= `VFCR_RST_SYNC_CTRL & `VFCR_MASK_SYNC_CTRL; // [R2] [R3] [R4] [R5]
      agc_reg <= `VFCR_RST_AGC_ENABLE; // [R6]
      g1_reg <= `VFCR_RST_GAIN_LOW; // [R7]
      g2_reg <= `VFCR_RST_GAIN_LOW; // [R7]
      g3_reg <= `VFCR_RST_GAIN_LOW; // [R7]
      g4_reg <= `VFCR_RST_GAIN_LOW; // [R7]
      ref_reg <= `VFCR_RST_ADC_REF & `VFCR_MASK_ADC_REF; // [R8] [R9] [R10]
      pd_reg <= `VFCR_RST_POWER_DOWN; // [R11]
      loss_reg <= `VFCR_RST_LOSS_MODE & `VFCR_MASK_LOSS_MODE; // [R12]
      fr_reg <= `VFCR_RST_FREERUN; // [R13] [R14] [R15] [R16]
      pk12_reg <= `VFCR_RST_PEAK;
      pk34_reg <= `VFCR_RST_PEAK;
      ct_reg <= `VFCR_RST_CLAMP_TEST; // [R17]
      at_reg <= `VFCR_RST_ANALOG_TEST;
      cs_reg <= `VFCR_RST_CORING_SW; // [R20] [R21]
    end else if (wr_go) begin
      if (hit_pclk) begin
        pclk_reg <= wd & `VFCR_MASK_PORT_CLK_GAIN;
      end
      if (hit_sync) begin
        sync_reg <= wd & `VFCR_MASK_SYNC_CTRL;
      end
      if (hit_agc) begin
        agc_reg <= wd;
      end
      if (hit_g1) begin
        g1_reg <= wd;
      end
      if (hit_g2) begin
        g2_reg <= wd;
      end
      if (hit_g3) begin
        g3_reg <= wd;
      end
      if (hit_g4) begin
        g4_reg <= wd;
      end
      if (hit_ref) begin
        ref_reg <= wd & `VFCR_MASK_ADC_REF;
      end
      if (hit_pd) begin
        pd_reg <= wd & `VFCR_MASK_POWER_DOWN;
      end
      if (hit_loss) begin
        loss_reg <= wd & `VFCR_MASK_LOSS_MODE;
      end
      if (hit_fr) begin
        fr_reg <= wd;
      end
      if (hit_pk12) begin
        pk12_reg <= wd;
      end
      if (hit_pk34) begin
        pk34_reg <= wd;
      end
      if (hit_ct) begin
        ct_reg <= wd & `VFCR_MASK_CLAMP_TEST;
      end
      if (hit_at) begin
        at_reg <= wd;
      end
      if (hit_cs) begin
        cs_reg <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field extraction

  wire vsync_align_select = sync_reg[`VFCR_POS_VSYNC_ALIGN_SELECT];
  wire field_flag_polarity = sync_reg[`VFCR_POS_FIELD_FLAG_POLARITY];
  wire hsync_polarity = sync_reg[`VFCR_POS_HSYNC_POLARITY];
  wire vsync_polarity = sync_reg[`VFCR_POS_VSYNC_POLARITY];
  wire [3:0] auto_gain_loop_off = agc_reg[`VFCR_POS_AGC_OFF +: 4];
  wire [3:0] gain_msb = agc_reg[`VFCR_POS_GAIN_MSB +: 4];
  // Bit 8 of each channel's gain lives in the shared enable register
  wire [35:0] manual_gain_value = {gain_msb[3], g4_reg, gain_msb[2], g3_reg,
                                   gain_msb[1], g2_reg, gain_msb[0], g1_reg}; // [R7]
  wire [2:0] gain_code_c = pclk_reg[`VFCR_POS_GAIN_C +: 3];
  wire [2:0] gain_code_y = pclk_reg[`VFCR_POS_GAIN_Y +: 3];
  wire port_clock_output_enable = pclk_reg[`VFCR_POS_PCLK_OE];
  wire [3:0] field_flag_status;
  wire [3:0] vertical_active_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  // Unmapped indices and byte lanes above the low one read as zero
  assign rd_byte = ({8{hit_pclk}} & pclk_reg)
                 | ({8{hit_sync}} & (sync_reg | `VFCR_FIX_SYNC_CTRL)) // [R23]
                 | ({8{hit_agc}} & agc_reg)
                 | ({8{hit_g1}} & g1_reg)
                 | ({8{hit_g2}} & g2_reg)
                 | ({8{hit_g3}} & g3_reg)
                 | ({8{hit_g4}} & g4_reg)
                 | ({8{hit_ref}} & ref_reg)
                 | ({8{hit_pd}} & pd_reg)
                 | ({8{hit_loss}} & (loss_reg | `VFCR_FIX_LOSS_MODE)) // [R23]
                 | ({8{hit_fr}} & fr_reg)
                 | ({8{hit_pk12}} & pk12_reg)
                 | ({8{hit_pk34}} & pk34_reg)
                 | ({8{hit_ct}} & ct_reg)
                 | ({8{hit_st}} & {field_flag_status, vertical_active_status}) // [R18] [R19]
                 | ({8{hit_at}} & at_reg)
                 | ({8{hit_cs}} & cs_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel sync shaping and gain selection

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      vfcr_sync_shaper u_shaper (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .vsync_align_select_i(vsync_align_select),
        .field_flag_polarity_i(field_flag_polarity),
        .hsync_polarity_i(hsync_polarity),
        .vsync_polarity_i(vsync_polarity),
        .hsync_raw_i(HSYNC_RAW_I[ch]),
        .vsync_raw_i(VSYNC_RAW_I[ch]),
        .odd_field_i(ODD_FIELD_I[ch]),
        .hsync_o(HSYNC_O[ch]),
        .vsync_o(VSYNC_O[ch]),
        .field_o(FIELD_O[ch])
      );
      vfcr_gain_select u_gain (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .auto_gain_loop_off_i(auto_gain_loop_off[ch]),
        .manual_gain_value_i(manual_gain_value[ch*9 +: 9]),
        .loop_gain_i(LOOP_GAIN_I[ch*9 +: 9]),
        .gain_o(CH_GAIN_O[ch*9 +: 9])
      );
    end
  endgenerate

  // Status shows the shaped field flag, so it follows the polarity bit
  assign field_flag_status = FIELD_O; // [R18]
  assign vertical_active_status = vact_reg; // [R19]

  ////////////////////////////////////////////////////////////////////////////////
  // Registered control outputs

  logic [3:0] vact_reg;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      vact_reg <= 4'h0;
      PORT_CLK_O <= 2'h0;
      PORT_CLK_OE_O <= 2'h0;
      DAC_GAIN_Y_O <= 6'h00;
      DAC_GAIN_C_O <= 6'h00;
      AGC_LOOP_OFF_O <= 4'h0;
    end else begin
      vact_reg <= VACTIVE_I; // [R19]
      PORT_CLK_O <= PORT_CLK_SRC_I;
      PORT_CLK_OE_O <= {2{port_clock_output_enable}}; // [R22]
      DAC_GAIN_Y_O <= `VFCR_DAC_GAIN_BASE + {3'h0, gain_code_y}; // [R1]
      DAC_GAIN_C_O <= `VFCR_DAC_GAIN_BASE + {3'h0, gain_code_c}; // [R1]
      AGC_LOOP_OFF_O <= auto_gain_loop_off; // [R6]
    end
  end

  // Analog settings are copied from the bank one cycle after the write
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      CUR_REF_BOOST_O <= 1'b0;
      VOLT_REF_OFF_O <= 1'b0;
      VIDEO_AA_EN_O <= 1'b0;
      VIDEO_LOW_POWER_O <= 1'b0;
      AUDIO_DAC_PD_O <= 1'b0;
      AUDIO_ADC_PD_O <= 1'b0;
      VIDEO_ADC_PD_O <= 4'h0;
      LOSS_FLAG_SPEED_O <= 2'h0;
      FREERUN_SELECT_O <= 2'h0;
      LUMA_NOISE_REDUCE_O <= 2'h0;
      CLAMP_MODE_O <= 2'h0;
      SLICE_LEVEL_O <= 2'h0;
      AUDIO_AA_EN_O <= 1'b0;
      PEAKING_TEST_O <= 16'h0000;
      CLAMP_TEST_O <= 8'h00;
      ANALOG_TEST_O <= 8'h00;
      INPUT_SOURCE_SEL_O <= 4'h0;
      SHARP_CORING_O <= 4'h0;
    end else begin
      CUR_REF_BOOST_O <= ref_reg[`VFCR_POS_CURRENT_REF_BOOST]; // [R8]
      VOLT_REF_OFF_O <= ref_reg[`VFCR_POS_VREF]; // [R9]
      VIDEO_AA_EN_O <= ref_reg[`VFCR_POS_VAA]; // [R10]
      VIDEO_LOW_POWER_O <= ref_reg[`VFCR_POS_VLP]; // [R10]
      AUDIO_DAC_PD_O <= pd_reg[`VFCR_POS_AUDIO_DAC_POWER_DOWN]; // [R11]
      AUDIO_ADC_PD_O <= pd_reg[`VFCR_POS_AUDIO_ADC_POWER_DOWN]; // [R11]
      VIDEO_ADC_PD_O <= pd_reg[`VFCR_POS_VIDEO_ADC_POWER_DOWN +: 4]; // [R11]
      LOSS_FLAG_SPEED_O <= loss_reg[`VFCR_POS_LOSS +: 2]; // [R12]
      FREERUN_SELECT_O <= fr_reg[`VFCR_POS_FMR +: 2]; // [R13]
      LUMA_NOISE_REDUCE_O <= fr_reg[`VFCR_POS_YNR +: 2]; // [R14]
      CLAMP_MODE_O <= fr_reg[`VFCR_POS_CLAMP_MODE_SELECT +: 2]; // [R15]
      SLICE_LEVEL_O <= fr_reg[`VFCR_POS_PSP +: 2]; // [R16]
      AUDIO_AA_EN_O <= ct_reg[`VFCR_POS_AAA]; // [R17]
      PEAKING_TEST_O <= {pk34_reg, pk12_reg};
      CLAMP_TEST_O <= ct_reg;
      ANALOG_TEST_O <= at_reg;
      INPUT_SOURCE_SEL_O <= cs_reg[`VFCR_POS_INSEL +: 4]; // [R20]
      SHARP_CORING_O <= cs_reg[`VFCR_POS_CORING +: 4]; // [R21]
    end
  end

endmodule

// file: vfcr_top_monitor.sv
// Concurrent checks on the ports of the front-end register bank
`timescale 1ns/1ns
module vfcr_top_monitor (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Register bus
  input wire logic [9:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Timing and gain
  input wire logic [3:0] HSYNC_RAW_I,
  input wire logic [3:0] VACTIVE_I,
  input wire logic [35:0] LOOP_GAIN_I,
  input wire logic [3:0] HSYNC_O,
  input wire logic [3:0] FIELD_O,
  input wire logic [1:0] PORT_CLK_OE_O,
  input wire logic [5:0] DAC_GAIN_Y_O,
  input wire logic [5:0] DAC_GAIN_C_O,
  input wire logic [3:0] AGC_LOOP_OFF_O,
  input wire logic [35:0] CH_GAIN_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////
  // Outputs show reset values one edge after release; wait three
  logic [1:0] up_cnt_reg;
  wire [7:0] idx = AVS_ADDRESS_I[9:2];
  wire up = up_cnt_reg == 2'h3;
  wire rd_done = AVS_READ_I && !AVS_WAITREQUEST_O;
  wire unmapped = idx < 8'h41 || idx > 8'h57 ||
    idx inside {8'h42, 8'h43, 8'h44, 8'h4e, 8'h53, 8'h54};
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      up_cnt_reg <= 2'h0;
    end else if (!up) begin
      up_cnt_reg <= up_cnt_reg + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_wait_one_cycle: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("access not answered after one wait");
  a_wait_low_once: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");
  a_data_upper_zero: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (rd_done && unmapped |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_dac_gain_range: assert property (up |-> DAC_GAIN_Y_O inside {[6'h1d:6'h24]} &&
    DAC_GAIN_C_O inside {[6'h1d:6'h24]}) else $error("dac gain outside range");
  a_hsync_follows: assert property (up |-> (HSYNC_O ^ $past(HSYNC_RAW_I)) inside {4'h0, 4'hf})
    else $error("hsync output not raw or inverted raw");
  a_loop_gain_pass: assert property ((up && !AGC_LOOP_OFF_O[0] && $stable(LOOP_GAIN_I))[*3]
    |-> CH_GAIN_O[8:0] == LOOP_GAIN_I[8:0]) else $error("loop gain not passed through");
  a_clk_oe_pair: assert property (up |-> PORT_CLK_OE_O inside {2'h0, 2'h3})
    else $error("port clock enables differ");
  a_field_status: assert property (rd_done && idx == 8'h55
    |-> AVS_READDATA_O[7:4] == $past(FIELD_O)) else $error("field status wrong");
  a_vactive_status: assert property (rd_done && idx == 8'h55
    |-> AVS_READDATA_O[3:0] == $past(VACTIVE_I, 2)) else $error("vertical active status wrong");
endmodule
bind vfcr_top vfcr_top_monitor mon_u (.*);

// file: vfcr_top_tb.sv
// Self-checking bench for the front-end register bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module vfcr_top_tb;
  localparam int LIMIT = 5000;
  localparam logic [35:0] LG = 36'h1_2345_6789;
  localparam logic [35:0] FIN_GAIN = {9'h0ff, LG[26:18], 9'h101, LG[8:0]};
  localparam logic [78:0] RST_VEC = {6'h24, 6'h24, 2'h0, 4'h0, 6'h08, 4'h0, 2'h3, 2'h0,
    2'h0, 2'h1, 2'h1, 1'b0, 16'h0, 8'h0, 8'h0, 4'h0, 4'h3};
  localparam logic [78:0] FIN_VEC = {6'h1d, 6'h1d, 2'h3, 4'ha, 6'h3f, 4'hf, 2'h0, 2'h2,
    2'h2, 2'h1, 2'h2, 1'b1, 16'h3412, 8'hdf, 8'hc3, 4'hc, 4'h9};
  // Rows: index, reset value, write data, value read back
  localparam logic [31:0] ROWS [16] = '{32'h41_77_80_80, 32'h45_d1_3c_fd, 32'h46_00_a6_a6,
    32'h47_f0_5a_5a, 32'h48_f0_01_01, 32'h49_f0_80_80, 32'h4a_f0_ff_ff, 32'h4b_02_ff_63,
    32'h4c_00_ff_3f, 32'h4d_0f_00_03, 32'h4f_05_a6_a6, 32'h50_00_12_12, 32'h51_00_34_34,
    32'h52_00_ff_df, 32'h56_00_c3_c3, 32'h57_30_9c_9c};
  logic CORE_CLK_I = 1'b0, RST_I = 1'b1, AVS_READ_I = 1'b0, AVS_WRITE_I = 1'b0;
  logic [9:0] AVS_ADDRESS_I = 10'h0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0, AVS_READDATA_O;
  logic [3:0] AVS_BYTEENABLE_I = 4'h1, HSYNC_RAW_I = 4'h0, VSYNC_RAW_I = 4'h0;
  logic [3:0] ODD_FIELD_I = 4'h0, VACTIVE_I = 4'h0, HSYNC_O, VSYNC_O, FIELD_O;
  logic [35:0] LOOP_GAIN_I = LG, CH_GAIN_O;
  logic [1:0] PORT_CLK_SRC_I = 2'h2, PORT_CLK_O, PORT_CLK_OE_O, LOSS_FLAG_SPEED_O;
  logic [1:0] FREERUN_SELECT_O, LUMA_NOISE_REDUCE_O, CLAMP_MODE_O, SLICE_LEVEL_O;
  logic AVS_WAITREQUEST_O, CUR_REF_BOOST_O, VOLT_REF_OFF_O, VIDEO_AA_EN_O, VIDEO_LOW_POWER_O;
  logic AUDIO_DAC_PD_O, AUDIO_ADC_PD_O, AUDIO_AA_EN_O;
  logic [3:0] AGC_LOOP_OFF_O, VIDEO_ADC_PD_O, INPUT_SOURCE_SEL_O, SHARP_CORING_O;
  logic [5:0] DAC_GAIN_Y_O, DAC_GAIN_C_O;
  logic [15:0] PEAKING_TEST_O;
  logic [7:0] CLAMP_TEST_O, ANALOG_TEST_O, rd;
  int miscompares = 0, n_checks = 0, cycles = 0;
  wire [78:0] ctl = {DAC_GAIN_Y_O, DAC_GAIN_C_O, PORT_CLK_OE_O, AGC_LOOP_OFF_O,
    CUR_REF_BOOST_O, VOLT_REF_OFF_O, VIDEO_AA_EN_O, VIDEO_LOW_POWER_O, AUDIO_DAC_PD_O,
    AUDIO_ADC_PD_O, VIDEO_ADC_PD_O, LOSS_FLAG_SPEED_O, FREERUN_SELECT_O, LUMA_NOISE_REDUCE_O,
    CLAMP_MODE_O, SLICE_LEVEL_O, AUDIO_AA_EN_O, PEAKING_TEST_O, CLAMP_TEST_O, ANALOG_TEST_O,
    INPUT_SOURCE_SEL_O, SHARP_CORING_O};
  wire [11:0] syncs = {HSYNC_O, VSYNC_O, FIELD_O};

  vfcr_top dut_u (.*);

  always #25 CORE_CLK_I = ~CORE_CLK_I;
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge CORE_CLK_I) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  // Holds the request until waitrequest is sampled low; no latency assumed
  task automatic xfer(input logic rd_en, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge CORE_CLK_I);
    AVS_READ_I <= rd_en;
    AVS_WRITE_I <= !rd_en;
    AVS_ADDRESS_I <= {idx, 2'b00};
    AVS_WRITEDATA_I <= {24'h0, wd};
    @(posedge CORE_CLK_I);
    while (AVS_WAITREQUEST_O !== 1'b0 && n < 20) begin
      @(posedge CORE_CLK_I);
      n++;
    end
    if (n == 20) miscompares++;
    rd = AVS_READDATA_O[7:0];
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CORE_CLK_I);
  endtask

  task automatic reset_check();
    settle(3);
    `CHK("reset outputs", RST_VEC, ctl)
    `CHK("reset gains", LG, CH_GAIN_O)
    `CHK("reset hsync", 4'hf, HSYNC_O)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(20);
    RST_I <= 1'b0;
    reset_check();
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, ROWS[i][31:24], 8'h0);
      `CHK("reset value", ROWS[i][23:16], rd)
      xfer(1'b0, ROWS[i][31:24], ROWS[i][15:8]);
      xfer(1'b1, ROWS[i][31:24], 8'h0);
      `CHK("readback", ROWS[i][7:0], rd)
    end
    settle(3);
    `CHK("control outputs", FIN_VEC, ctl)
    `CHK("channel gains", FIN_GAIN, CH_GAIN_O)
    `CHK("port clock", 2'h2, PORT_CLK_O)
    // Sync polarity, all set
    HSYNC_RAW_I <= 4'h5;
    settle(3);
    `CHK("hsync high", 4'h5, HSYNC_O)
    HSYNC_RAW_I <= 4'h0;
    xfer(1'b0, 8'h45, 8'hc1);
    VSYNC_RAW_I <= 4'h3;
    ODD_FIELD_I <= 4'h6;
    VACTIVE_I <= 4'h9;
    settle(4);
    `CHK("syncs low", 12'hfc6, syncs)
    xfer(1'b1, 8'h55, 8'h0);
    `CHK("status odd high", 8'h69, rd)
    // Status is read-only; field flag even high
    xfer(1'b0, 8'h55, 8'hff);
    xfer(1'b0, 8'h45, 8'hd1);
    settle(3);
    `CHK("field even high", 4'h9, FIELD_O)
    xfer(1'b1, 8'h55, 8'h0);
    `CHK("status even high", 8'h99, rd)
    // Vsync aligned to hsync edges
    xfer(1'b0, 8'h45, 8'hf1);
    HSYNC_RAW_I <= 4'hf;
    settle(4);
    HSYNC_RAW_I <= 4'h0;
    VSYNC_RAW_I <= 4'hc;
    settle(4);
    `CHK("vsync held", 4'hc, VSYNC_O)
    HSYNC_RAW_I <= 4'hf;
    settle(4);
    `CHK("vsync on hsync", 4'h3, VSYNC_O)
    HSYNC_RAW_I <= 4'h0;
    // Byte lane off and unmapped places are refused
    AVS_BYTEENABLE_I <= 4'h0;
    xfer(1'b0, 8'h57, 8'h00);
    AVS_BYTEENABLE_I <= 4'h1;
    xfer(1'b1, 8'h57, 8'h0);
    `CHK("byte lane off", 8'h9c, rd)
    foreach (ROWS[i]) begin
      if (i < 4) begin
        xfer(1'b0, 8'h42 + 8'(i * 12), 8'hff);
        xfer(1'b1, 8'h42 + 8'(i * 12), 8'h0);
        `CHK("unmapped", 8'h00, rd)
      end
    end
    // Second reset in mid-run
    RST_I <= 1'b1;
    settle(20);
    RST_I <= 1'b0;
    reset_check();
    xfer(1'b1, 8'h45, 8'h0);
    `CHK("sync control after reset", 8'hd1, rd)
    print_verdict();
  end
endmodule
